/* File: rtl/ifmc_mode_control.sv */
// Operating-mode control register and enable decode for the IF receiver
`timescale 1ns/1ps
`default_nettype none
module ifmc_mode_control (
    // Clock and power-down pin
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control word load from the serial front end
    input  wire logic        word_load,
    input  wire logic [12:0] word_data,
    // Optional control pins, each with a driven sense
    input  wire logic        standby_control_driven,
    input  wire logic        standby_control_n,
    input  wire logic        lo_buffer_enable_driven,
    input  wire logic        lo_buffer_enable_n,
    input  wire logic        divider_set_pin_driven,
    input  wire logic        divider_set_pin,
    input  wire logic        mode_pin_driven,
    input  wire logic        mode_pin,
    // Register readback
    output logic [12:0]      operating_mode_control,
    // Enables and selects
    output logic             serial_bus_on,
    output logic             gain_amp_on,
    output logic             demod_on,
    output logic             synth_on,
    output logic             input_cdma_sel,
    output logic             q_path_on,
    output logic             high_band_oscillator,
    output logic             low_band_oscillator,
    output logic             oscillator_bypass,
    output logic             lo_buffered_on,
    output logic             lo_halving_on,
    output logic             divider_set_one,
    output logic             turbo_on,
    output logic             pump_polarity,
    output logic             lo_i_phase,
    output logic             lo_q_phase,
    output logic [1:0]       power_state
);
    logic [12:0]            ctrl;
    logic [12:0]            next_ctrl;
    ifmc_pkg::ifmc_state_t  state;
    ifmc_pkg::ifmc_state_t  next_state;
    logic                   sb_eff;
    logic                   be_eff;
    logic                   ds_eff;
    logic                   is_eff;
    logic                   vs_eff;
    logic                   ds_res;
    logic                   lo_i;
    logic                   lo_q;
    logic                   next_lo_i;
    logic                   next_lo_q;
    logic                   next_serial_bus_on;
    logic                   next_gain_amp_on;
    logic                   next_demod_on;
    logic                   next_synth_on;
    logic                   next_q_path_on;
    logic                   next_input_cdma_sel;
    logic                   next_high_band_oscillator;
    logic                   next_low_band_oscillator;
    logic                   next_oscillator_bypass;
    logic                   next_divider_set_one;
    logic                   next_turbo_on;
    logic                   next_pump_polarity;
    logic                   next_lo_buffered_on;
    logic                   next_lo_halving_on;
    logic                   next_lo_i_phase;
    logic                   next_lo_q_phase;

    // Oscillator and synthesizer run in standby as well as when active
    function automatic logic osc_live_of(input ifmc_pkg::ifmc_state_t s);
        case (s)
            ifmc_pkg::IFMC_STANDBY: osc_live_of = 1'b1;
            ifmc_pkg::IFMC_ACTIVE:  osc_live_of = 1'b1;
            default:                osc_live_of = 1'b0;
        endcase
    endfunction

    // Gain amplifier and demodulator run only when fully active
    function automatic logic path_live_of(input ifmc_pkg::ifmc_state_t s);
        case (s)
            ifmc_pkg::IFMC_ACTIVE: path_live_of = 1'b1;
            default:               path_live_of = 1'b0;
        endcase
    endfunction

    // Pins resolved against the word
    ifmc_pin_override u_sb (
        .pin_driven (standby_control_driven),
        .pin_level  (standby_control_n),
        .reg_bit    (ctrl[ifmc_pkg::BIT_STANDBY]),
        .value      (sb_eff)
    );
    ifmc_pin_override u_be (
        .pin_driven (lo_buffer_enable_driven),
        .pin_level  (lo_buffer_enable_n),
        .reg_bit    (ctrl[ifmc_pkg::BIT_LO_OUTPUT_ON]),
        .value      (be_eff)
    );
    ifmc_pin_override u_ds (
        .pin_driven (divider_set_pin_driven),
        .pin_level  (divider_set_pin),
        .reg_bit    (ctrl[ifmc_pkg::BIT_DIVIDER_SET]),
        .value      (ds_res)
    );
    ifmc_pin_override u_is (
        .pin_driven (mode_pin_driven),
        .pin_level  (mode_pin),
        .reg_bit    (ctrl[ifmc_pkg::BIT_INPUT_PORT]),
        .value      (is_eff)
    );
    ifmc_pin_override u_vs (
        .pin_driven (mode_pin_driven),
        .pin_level  (mode_pin),
        .reg_bit    (ctrl[ifmc_pkg::BIT_OSC_CHOICE]),
        .value      (vs_eff)
    );
    // Mode pin also steers the divider set, ahead of the divider pin
    ifmc_pin_override u_md (
        .pin_driven (mode_pin_driven),
        .pin_level  (mode_pin),
        .reg_bit    (ds_res),
        .value      (ds_eff)
    );

    // Control word storage; pin low wipes it back to power-up state
    always_comb begin
        next_ctrl = ctrl;
        if (word_load) begin
            next_ctrl = word_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= ifmc_pkg::CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Power state decode; the register power-down bit outranks standby
    always_comb begin
        case ({ctrl[ifmc_pkg::BIT_POWER_DOWN], sb_eff})
            2'h0:    next_state = ifmc_pkg::IFMC_REG_OFF;
            2'h1:    next_state = ifmc_pkg::IFMC_REG_OFF;
            2'h2:    next_state = ifmc_pkg::IFMC_STANDBY;
            default: next_state = ifmc_pkg::IFMC_ACTIVE;
        endcase
    end

    // LO phase latches: a two-stage ring puts I and Q a quarter period apart
    // The system clock stands in for the oscillator, so the phases only
    // show the ring order, not the real LO rate; this keeps one clock domain
    always_comb begin
        next_lo_i       = 1'b0;
        next_lo_q       = 1'b0;
        next_lo_i_phase = lo_i;
        next_lo_q_phase = lo_q;
        if (osc_live_of(state)) begin
            next_lo_i = ~lo_q;
            next_lo_q = lo_i;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_i       <= 1'b0;
            lo_q       <= 1'b0;
            lo_i_phase <= 1'b0;
            lo_q_phase <= 1'b0;
        end else begin
            lo_i       <= next_lo_i;
            lo_q       <= next_lo_q;
            lo_i_phase <= next_lo_i_phase;
            lo_q_phase <= next_lo_q_phase;
        end
    end

    // Power and signal path; the serial bus stays up whenever the pin is high
    always_comb begin
        next_serial_bus_on = 1'b1;
        // Signal path only when fully active
        next_gain_amp_on   = path_live_of(next_state);
        next_demod_on      = path_live_of(next_state);
        // Standby keeps LO and synthesizer up
        next_synth_on      = osc_live_of(next_state);
        // In FM mode a kind bit of 1 drops the Q path
        next_q_path_on     = path_live_of(next_state) &&
                             (is_eff || !ctrl[ifmc_pkg::BIT_FM_KIND]);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state         <= ifmc_pkg::IFMC_OFF;
            power_state   <= 2'h0;
            serial_bus_on <= 1'b0;
            gain_amp_on   <= 1'b0;
            demod_on      <= 1'b0;
            synth_on      <= 1'b0;
            q_path_on     <= 1'b0;
        end else begin
            state         <= next_state;
            power_state   <= next_state;
            serial_bus_on <= next_serial_bus_on;
            gain_amp_on   <= next_gain_amp_on;
            demod_on      <= next_demod_on;
            synth_on      <= next_synth_on;
            q_path_on     <= next_q_path_on;
        end
    end

    // Oscillator choice; bypass turns both internal oscillators off
    always_comb begin
        next_high_band_oscillator = osc_live_of(next_state) &&
                                    !ctrl[ifmc_pkg::BIT_OSC_BYPASS] && vs_eff;
        next_low_band_oscillator  = osc_live_of(next_state) &&
                                    !ctrl[ifmc_pkg::BIT_OSC_BYPASS] && !vs_eff;
        next_oscillator_bypass    = ctrl[ifmc_pkg::BIT_OSC_BYPASS];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            high_band_oscillator <= 1'b0;
            low_band_oscillator  <= 1'b0;
            oscillator_bypass    <= 1'b0;
        end else begin
            high_band_oscillator <= next_high_band_oscillator;
            low_band_oscillator  <= next_low_band_oscillator;
            oscillator_bypass    <= next_oscillator_bypass;
        end
    end

    // Readback, input port, divider set and pump settings
    always_comb begin
        next_input_cdma_sel  = is_eff;
        next_divider_set_one = ds_eff;
        next_turbo_on        = ctrl[ifmc_pkg::BIT_TURBO];
        next_pump_polarity   = ctrl[ifmc_pkg::BIT_PUMP_POL];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            operating_mode_control <= '0;
            input_cdma_sel         <= 1'b0;
            divider_set_one        <= 1'b0;
            turbo_on               <= 1'b0;
            pump_polarity          <= 1'b0;
        end else begin
            operating_mode_control <= ctrl;
            input_cdma_sel         <= next_input_cdma_sel;
            divider_set_one        <= next_divider_set_one;
            turbo_on               <= next_turbo_on;
            pump_polarity          <= next_pump_polarity;
        end
    end

    // LO buffer stays usable in standby because the oscillator keeps running
    // Halving is only a select here; the divider itself sits in the analog path
    always_comb begin
        next_lo_buffered_on = osc_live_of(next_state) && !be_eff;
        next_lo_halving_on  = ctrl[ifmc_pkg::BIT_LO_HALVING];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_buffered_on <= 1'b0;
            lo_halving_on  <= 1'b0;
        end else begin
            lo_buffered_on <= next_lo_buffered_on;
            lo_halving_on  <= next_lo_halving_on;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ifmc_pkg.sv */
// Constants for the IF receiver mode-control block
package ifmc_pkg;
    localparam int CTRL_W           = 13;
    localparam logic [12:0] CTRL_RESET = 13'h0B57;
    localparam int BIT_POWER_DOWN   = 0;
    localparam int BIT_STANDBY      = 1;
    localparam int BIT_INPUT_PORT   = 2;
    localparam int BIT_FM_KIND      = 3;
    localparam int BIT_LO_OUTPUT_ON = 4;
    localparam int BIT_LO_HALVING   = 5;
    localparam int BIT_OSC_CHOICE   = 6;
    localparam int BIT_OSC_BYPASS   = 7;
    localparam int BIT_DIVIDER_SET  = 8;
    localparam int BIT_TURBO        = 9;
    localparam int BIT_TEST_ENABLE  = 10;
    localparam int BIT_PUMP_POL     = 11;
    localparam int BIT_TEST_MODE    = 12;
    typedef enum logic [1:0] {
        IFMC_OFF     = 2'b00,
        IFMC_REG_OFF = 2'b01,
        IFMC_STANDBY = 2'b10,
        IFMC_ACTIVE  = 2'b11
    } ifmc_state_t;
endpackage

/* File: rtl/ifmc_pin_override.sv */
// Resolves a tri-state control pin against its register bit
`timescale 1ns/1ps
`default_nettype none
module ifmc_pin_override (
    // Pin sense
    input  wire logic pin_driven,
    input  wire logic pin_level,
    // Register bit
    input  wire logic reg_bit,
    // Result
    output logic      value
);
    // A floating pin hands control back to the register
    assign value = pin_driven ? pin_level : reg_bit;
endmodule
`default_nettype wire

/* File: sim/ifmc_mode_control_assertions.sv */
// Port checker for the IF receiver mode-control block
`timescale 1ns/1ps
`default_nettype none
module ifmc_mode_control_assertions (
    // Clock, power-down pin and control word
    input wire logic        clk, rst_n, word_load,
    input wire logic [12:0] word_data, operating_mode_control,
    // Control pins
    input wire logic        standby_control_driven, standby_control_n, lo_buffer_enable_driven,
    input wire logic        lo_buffer_enable_n, divider_set_pin_driven, divider_set_pin,
    input wire logic        mode_pin_driven, mode_pin,
    // Decoded outputs
    input wire logic        serial_bus_on, gain_amp_on, demod_on, synth_on, input_cdma_sel,
    input wire logic        q_path_on, high_band_oscillator, oscillator_bypass,
    input wire logic        lo_buffered_on, lo_halving_on, divider_set_one,
    input wire logic        lo_i_phase, lo_q_phase,
    input wire logic [1:0]  power_state
);
    // Pins as the design sampled them one edge earlier
    logic        up;
    logic [7:0]  p;
    wire  [12:0] c = operating_mode_control;
    always_ff @(posedge clk) begin
        up <= rst_n;
        p <= {mode_pin, mode_pin_driven, divider_set_pin, divider_set_pin_driven,
              lo_buffer_enable_n, lo_buffer_enable_driven, standby_control_n,
              standby_control_driven};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    pin_off_a: assert property ($rose(rst_n) |-> power_state == 2'h0 && !serial_bus_on)
        else $error("outputs live after power-down");
    word_echo_a: assert property (word_load |=> ##1 c == $past(word_data, 2))
        else $error("readback differs from loaded word");
    reg_off_a: assert property (up && !c[0] |-> power_state == 2'h1 && serial_bus_on
        && !synth_on && !gain_amp_on)
        else $error("register power-down decode wrong");
    bit_standby_a: assert property (up && c[1:0] == 2'h1 && !p[0] |->
        power_state == 2'h2 && !q_path_on && !demod_on)
        else $error("standby bit not honoured");
    pin_standby_a: assert property (up && c[0] && p[1:0] == 2'h1 |->
        power_state == 2'h2 && !gain_amp_on && synth_on)
        else $error("standby pin not honoured");
    pin_wins_a: assert property (up && c[1:0] == 2'h1 && p[1:0] == 2'h3 |->
        power_state == 2'h3 && demod_on)
        else $error("driven standby pin did not override");
    lo_buffer_a: assert property (power_state == 2'h3 |->
        lo_buffered_on == !(p[2] ? p[3] : c[4]))
        else $error("LO buffer enable wrong");
    mode_pin_a: assert property (up && p[6] |-> input_cdma_sel == p[7]
        && divider_set_one == p[7])
        else $error("mode pin did not override");
    div_pin_a: assert property (up && !p[6] |-> input_cdma_sel == c[2]
        && divider_set_one == (p[4] ? p[5] : c[8]))
        else $error("divider set choice wrong");
    fm_kind_a: assert property (power_state == 2'h3 |-> q_path_on == (input_cdma_sel || !c[3]))
        else $error("quadrature path enable wrong");
    osc_sel_a: assert property (power_state[1] && !p[6] |-> oscillator_bypass == c[7]
        && high_band_oscillator == (c[6] && !c[7]) && lo_halving_on == c[5])
        else $error("oscillator or halving decode wrong");
    lo_ring_a: assert property ($past(power_state[1], 2) |->
        lo_q_phase == $past(lo_i_phase) && lo_i_phase != $past(lo_q_phase))
        else $error("LO phase order wrong");
endmodule
bind ifmc_mode_control ifmc_mode_control_assertions ifmc_mode_control_assertions_inst (.*);
`default_nettype wire

/* File: sim/ifmc_ctrl_model.sv */
// Baseband controller model: control word loads and control pins
`timescale 1ns/1ps
`default_nettype none
module ifmc_ctrl_model (
    // Clock
    input  wire logic   clk,
    // Control word
    output logic        word_load,
    output logic [12:0] word_data,
    // Control pins with driven flags
    output logic        standby_control_driven, standby_control_n, lo_buffer_enable_driven,
    output logic        lo_buffer_enable_n, divider_set_pin_driven, divider_set_pin,
    output logic        mode_pin_driven, mode_pin
);
    initial begin
        {word_load, word_data, standby_control_driven, standby_control_n} = '0;
        {lo_buffer_enable_driven, lo_buffer_enable_n, divider_set_pin_driven} = '0;
        {divider_set_pin, mode_pin_driven, mode_pin} = '0;
    end
    task automatic load(input logic [12:0] w);
        @(posedge clk);
        word_load <= 1'b1;
        word_data <= w & 13'h0BFF;
        @(posedge clk);
        word_load <= 1'b0;
        word_data <= ~w;
    endtask
    // Drive flags and levels as {mode, divider, buffer, standby}
    task automatic pins(input logic [3:0] drv, input logic [3:0] lvl);
        @(posedge clk);
        {mode_pin_driven, divider_set_pin_driven, lo_buffer_enable_driven,
         standby_control_driven} <= drv;
        // A floating pin shows no stable level
        mode_pin <= drv[3] ? lvl[3] : ~mode_pin;
        divider_set_pin <= drv[2] ? lvl[2] : ~divider_set_pin;
        lo_buffer_enable_n <= drv[1] ? lvl[1] : ~lo_buffer_enable_n;
        standby_control_n <= drv[0] ? lvl[0] : ~standby_control_n;
    endtask
endmodule
`default_nettype wire

/* File: sim/if_receiver_mode_control_tb_top.sv */
// Self-checking bench for the IF receiver mode-control block
`timescale 1ns/1ps
`default_nettype none
module if_receiver_mode_control_tb_top;
    logic clk, rst_n, word_load, standby_control_driven, standby_control_n;
    logic lo_buffer_enable_driven, lo_buffer_enable_n, divider_set_pin_driven, divider_set_pin;
    logic mode_pin_driven, mode_pin, serial_bus_on, gain_amp_on, demod_on, synth_on;
    logic input_cdma_sel, q_path_on, high_band_oscillator, low_band_oscillator;
    logic oscillator_bypass, lo_buffered_on, lo_halving_on, divider_set_one, turbo_on;
    logic pump_polarity, lo_i_phase, lo_q_phase;
    logic [12:0] word_data, operating_mode_control, w;
    logic [1:0]  power_state, ps;
    int          errors, cmp_count, cycles;
    logic [12:0] words [7] = '{13'h0B56, 13'h0B55, 13'h0B5B, 13'h0B53, 13'h0BE7, 13'h0A17,
                               13'h1F57};
    ifmc_mode_control ifmc_mode_control_inst (.*);
    ifmc_ctrl_model ifmc_ctrl_model_inst (.*);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #10;
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        chk("readback", ifmc_pkg::CTRL_RESET, operating_mode_control);
        chk("state", 2'h3, power_state);
        ps = {lo_i_phase, lo_q_phase};
        @(posedge clk);
        #10;
        chk("lo phase", {~ps[0], ps[1]}, {lo_i_phase, lo_q_phase});
        foreach (words[i]) begin
            w = words[i] & 13'h0BFF;
            ifmc_ctrl_model_inst.load(words[i]);
            settle();
            ps = !w[0] ? 2'h1 : (!w[1] ? 2'h2 : 2'h3);
            chk("readback", w, operating_mode_control);
            chk("state", ps, power_state);
            chk("gain", ps == 2'h3, gain_amp_on);
            chk("demod", ps == 2'h3, demod_on);
            chk("synth", ps != 2'h1, synth_on);
            chk("turbo", w[9], turbo_on);
            chk("pump", w[11], pump_polarity);
            chk("q path", ps == 2'h3 && (w[2] || !w[3]), q_path_on);
            chk("cdma", w[2], input_cdma_sel);
            chk("high osc", ps[1] && w[6] && !w[7], high_band_oscillator);
            chk("bypass", w[7], oscillator_bypass);
            chk("halving", w[5], lo_halving_on);
            chk("buffer", ps != 2'h1 && !w[4], lo_buffered_on);
            chk("divider", w[8], divider_set_one);
        end
        ifmc_ctrl_model_inst.load(13'h0B55);
        ifmc_ctrl_model_inst.pins(4'h1, 4'h1);
        settle();
        chk("state", 2'h3, power_state);
        ifmc_ctrl_model_inst.load(13'h0B57);
        ifmc_ctrl_model_inst.pins(4'h1, 4'h0);
        settle();
        chk("state", 2'h2, power_state);
        chk("synth", 1'b1, synth_on);
        chk("demod", 1'b0, demod_on);
        ifmc_ctrl_model_inst.pins(4'hE, 4'h4);
        settle();
        chk("cdma", 1'b0, input_cdma_sel);
        chk("divider", 1'b0, divider_set_one);
        chk("low osc", 1'b1, low_band_oscillator);
        chk("buffer", 1'b1, lo_buffered_on);
        ifmc_ctrl_model_inst.pins(4'h6, 4'h2);
        settle();
        chk("divider", 1'b0, divider_set_one);
        chk("buffer", 1'b0, lo_buffered_on);
        ifmc_ctrl_model_inst.load(13'h0A16);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #10;
        chk("bus", 1'b0, serial_bus_on);
        chk("state", 2'h0, power_state);
        @(posedge clk);
        rst_n <= 1'b1;
        settle();
        chk("readback", ifmc_pkg::CTRL_RESET, operating_mode_control);
        end_sim();
    end
endmodule
`default_nettype wire
